/* File: csf_pkg.sv */
// Constants and types shared by the status-flag and auxiliary-operand block.
// Assumes a single core clock domain and an 8-bit special-function bus.

package csf_pkg;

   // ==========================================================================
   // Data widths
   // ==========================================================================
   localparam int          CSF_DATA_W      = 8;
   localparam int          CSF_BANK_W      = 2;
   localparam int          CSF_REGNUM_W    = 3;
   localparam int          CSF_REGADDR_W   = CSF_BANK_W + CSF_REGNUM_W;
   localparam int          CSF_BITSEL_W    = 3;

   // ==========================================================================
   // Special-function addresses
   // ==========================================================================
   localparam logic [7:0]  CSF_ADDR_STATUS = 8'hD0;
   localparam logic [7:0]  CSF_ADDR_EXTRA  = 8'hF0;

   // ==========================================================================
   // Field positions of the program status word
   // ==========================================================================
   localparam int          CSF_POS_CARRY   = 7;
   localparam int          CSF_POS_AUX     = 6;
   localparam int          CSF_POS_UF0     = 5;
   localparam int          CSF_POS_BANK_HI = 4;
   localparam int          CSF_POS_BANK_LO = 3;
   localparam int          CSF_POS_EXCESS  = 2;
   localparam int          CSF_POS_UF1     = 1;
   localparam int          CSF_POS_PARITY  = 0;

   // ==========================================================================
   // Reset values and fixed figures
   // ==========================================================================
   localparam logic [7:0]  CSF_RST_STATUS  = 8'h00;
   localparam logic [7:0]  CSF_RST_EXTRA   = 8'h00;
   localparam logic [7:0]  CSF_RDATA_IDLE  = 8'h00;
   localparam logic [7:0]  CSF_BYTE_MAX    = 8'hFF;
   localparam logic [7:0]  CSF_ZERO_BYTE   = 8'h00;

   // ==========================================================================
   // Arithmetic operations presented by the core datapath
   // ==========================================================================
   typedef enum logic [2:0] {
      CSF_OP_NONE,
      CSF_OP_ADD,
      CSF_OP_ADDC,
      CSF_OP_SUBB,
      CSF_OP_MUL,
      CSF_OP_DIV
   } csf_op_type;

   // ==========================================================================
   // Complete state of the top module
   // ==========================================================================
   typedef struct packed {
      logic [7:0] extra;
      logic       carry;
      logic       aux;
      logic       uf0;
      logic [1:0] bank;
      logic       excess;
      logic       uf1;
      logic       parity;
      logic [7:0] rdata;
      logic [7:0] result;
      logic       result_vld;
      logic [4:0] reg_addr;
   } csf_state_type;

endpackage

/* File: csf_arith_unit.sv */
// Combinational arithmetic unit: result bytes and flag outcomes per operation.
// Assumes the caller registers every output and applies the flags only when
// an operation is presented.

`timescale 1ns/1ps
`default_nettype none

module csf_arith_unit
   import csf_pkg::*;
(
   input  wire csf_pkg::csf_op_type op_i,
   input  wire logic [7:0]          acc_i,
   input  wire logic [7:0]          operand_i,
   input  wire logic [7:0]          extra_i,
   input  wire logic                carry_i,
   output logic [7:0]               res_lo_o,
   output logic [7:0]               res_hi_o,
   output logic                     res_hi_we_o,
   output logic                     carry_o,
   output logic                     aux_o,
   output logic                     excess_o
);

   logic [8:0]  sum9;
   logic [4:0]  nib5;
   logic [15:0] prod;
   logic        cin;

   // ==========================================================================
   // Operation decode
   // ==========================================================================
   always_comb begin
      cin         = 1'b0;
      sum9        = '0;
      nib5        = '0;
      prod        = '0;
      res_lo_o    = CSF_ZERO_BYTE;
      res_hi_o    = CSF_ZERO_BYTE;
      res_hi_we_o = 1'b0;
      carry_o     = 1'b0;
      aux_o       = 1'b0;
      excess_o    = 1'b0;
      unique case (op_i)
         CSF_OP_ADD, CSF_OP_ADDC: begin
            cin      = (op_i == CSF_OP_ADDC) ? carry_i : 1'b0;
            sum9     = {1'b0, acc_i} + {1'b0, operand_i} + {8'h00, cin};
            nib5     = {1'b0, acc_i[3:0]} + {1'b0, operand_i[3:0]} + {4'h0, cin};
            res_lo_o = sum9[7:0];
            carry_o  = sum9[8];
            aux_o    = nib5[4];
            excess_o = (acc_i[7] == operand_i[7]) && (sum9[7] != acc_i[7]);
         end
         CSF_OP_SUBB: begin
            sum9     = {1'b0, acc_i} - {1'b0, operand_i} - {8'h00, carry_i};
            nib5     = {1'b0, acc_i[3:0]} - {1'b0, operand_i[3:0]} - {4'h0, carry_i};
            res_lo_o = sum9[7:0];
            carry_o  = sum9[8];
            aux_o    = nib5[4];
            excess_o = (acc_i[7] != operand_i[7]) && (sum9[7] != acc_i[7]);
         end
         CSF_OP_MUL: begin
            prod        = {8'h00, acc_i} * {8'h00, extra_i};
            res_lo_o    = prod[7:0];
            res_hi_o    = prod[15:8];
            res_hi_we_o = 1'b1;
            excess_o    = (prod > {8'h00, CSF_BYTE_MAX});
         end
         CSF_OP_DIV: begin
            if (extra_i == CSF_ZERO_BYTE) begin
               excess_o = 1'b1;
            end else begin
               res_lo_o    = acc_i / extra_i;
               res_hi_o    = acc_i % extra_i;
               res_hi_we_o = 1'b1;
            end
         end
         default: begin
            res_lo_o = CSF_ZERO_BYTE;
         end
      endcase
   end

endmodule

`default_nettype wire

/* File: csf_status_flags.sv */
// Program status word and auxiliary operand register of the core.
// Assumes a synchronous special-function bus from the core and an
// accumulator value presented every cycle by the core's register file.
//
// How it works
// - Operand register at 0xF0 is 8-bit read/write, bit-addressable and resets to zero.
// - The status word at 0xD0 is always reachable, bit-addressable and resets to zero.
// - Bit 7 is set by an add carry or a subtract borrow and cleared by other arithmetic.
// - Bit 6 is set by a carry or borrow out of the low nibble and cleared by other arithmetic.
// - Status bits 5 and 1 are software flags that hardware never alters.
// - Bits 4:3 select the working bank at data address 0x00, 0x08, 0x10 or 0x18 onward.
// - Status bit 2 is set by a signed overflow of add, add with carry or subtract with borrow.
// - Status bit 2 is set when a multiply yields a product above 255.
// - Status bit 2 is set when a divide is attempted with a zero divisor.
// - Those five operations clear status bit 2 when their overflow condition is absent.
// - Status bit 0 is read-only and shows odd parity of the accumulator.
// - Each bank holds eight byte registers numbered zero to seven.
// - Parity is taken over the main accumulator.

`timescale 1ns/1ps
`default_nettype none

module csf_status_flags
   import csf_pkg::*;
(
   input  wire logic                SYS_CLK_I,
   input  wire logic                SYS_RST_I,
   // Special-function register access.
   input  wire logic [7:0]          SFR_ADDR_I,
   input  wire logic                SFR_WR_I,
   input  wire logic [7:0]          SFR_WDATA_I,
   input  wire logic                SFR_RD_I,
   input  wire logic                SFR_BIT_WR_I,
   input  wire logic [2:0]          SFR_BIT_SEL_I,
   input  wire logic                SFR_BIT_VAL_I,
   output logic [7:0]               SFR_RDATA_O,
   // Arithmetic datapath.
   input  wire csf_pkg::csf_op_type ARITH_OP_I,
   input  wire logic [7:0]          ACC_I,
   input  wire logic [7:0]          OPERAND_I,
   output logic [7:0]               ARITH_RESULT_O,
   output logic                     ARITH_RESULT_VLD_O,
   // Working-register addressing.
   input  wire logic [2:0]          REG_NUM_I,
   output logic [4:0]               REG_ADDR_O,
   // Live views of the state.
   output logic [7:0]               PROGRAM_STATUS_O,
   output logic [7:0]               EXTRA_OPERAND_O,
   output logic [1:0]               BANK_SELECT_O,
   output logic                     CARRY_FLAG_O
);

   import csf_pkg::*;

   // ==========================================================================
   // State and helper signals
   // ==========================================================================
   csf_state_type state_ff;
   csf_state_type nxt_state;

   logic [7:0] au_res_lo;
   logic [7:0] au_res_hi;
   logic       au_res_hi_we;
   logic       au_carry;
   logic       au_aux;
   logic       au_excess;
   logic [7:0] status_view;
   logic       hit_status;
   logic       hit_extra;
   logic       arith_active;

   // ==========================================================================
   // Arithmetic unit
   // ==========================================================================
   csf_arith_unit u_arith (
      .op_i        (ARITH_OP_I),
      .acc_i       (ACC_I),
      .operand_i   (OPERAND_I),
      .extra_i     (state_ff.extra),
      .carry_i     (state_ff.carry),
      .res_lo_o    (au_res_lo),
      .res_hi_o    (au_res_hi),
      .res_hi_we_o (au_res_hi_we),
      .carry_o     (au_carry),
      .aux_o       (au_aux),
      .excess_o    (au_excess)
   );

   // ==========================================================================
   // Address decode and assembled status word
   // ==========================================================================
   always_comb begin
      hit_status   = (SFR_ADDR_I == CSF_ADDR_STATUS);
      hit_extra    = (SFR_ADDR_I == CSF_ADDR_EXTRA);
      arith_active = (ARITH_OP_I != CSF_OP_NONE);
      status_view                  = CSF_RST_STATUS;
      status_view[CSF_POS_CARRY]   = state_ff.carry;
      status_view[CSF_POS_AUX]     = state_ff.aux;
      status_view[CSF_POS_UF0]     = state_ff.uf0;
      status_view[CSF_POS_BANK_HI] = state_ff.bank[1];
      status_view[CSF_POS_BANK_LO] = state_ff.bank[0];
      status_view[CSF_POS_EXCESS]  = state_ff.excess;
      status_view[CSF_POS_UF1]     = state_ff.uf1;
      status_view[CSF_POS_PARITY]  = state_ff.parity;
   end

   // ==========================================================================
   // Next-state logic
   // ==========================================================================
   // Software writes are applied first; a flag that the datapath updates in
   // the same cycle takes the datapath value, so no arithmetic event is lost.
   always_comb begin
      nxt_state = state_ff;

      // Byte write to the status word; the parity position is dropped.
      if (SFR_WR_I && hit_status) begin
         nxt_state.carry  = SFR_WDATA_I[CSF_POS_CARRY];
         nxt_state.aux    = SFR_WDATA_I[CSF_POS_AUX];
         nxt_state.uf0    = SFR_WDATA_I[CSF_POS_UF0];
         nxt_state.bank   = SFR_WDATA_I[CSF_POS_BANK_HI:CSF_POS_BANK_LO];
         nxt_state.excess = SFR_WDATA_I[CSF_POS_EXCESS];
         nxt_state.uf1    = SFR_WDATA_I[CSF_POS_UF1];
      end

      // Byte write to the operand register.
      if (SFR_WR_I && hit_extra) begin
         nxt_state.extra = SFR_WDATA_I;
      end

      // Single-bit writes to either bit-addressable register.
      if (SFR_BIT_WR_I && hit_status) begin
         unique case (int'(SFR_BIT_SEL_I))
            CSF_POS_CARRY:   nxt_state.carry   = SFR_BIT_VAL_I;
            CSF_POS_AUX:     nxt_state.aux     = SFR_BIT_VAL_I;
            CSF_POS_UF0:     nxt_state.uf0     = SFR_BIT_VAL_I;
            CSF_POS_BANK_HI: nxt_state.bank[1] = SFR_BIT_VAL_I;
            CSF_POS_BANK_LO: nxt_state.bank[0] = SFR_BIT_VAL_I;
            CSF_POS_EXCESS:  nxt_state.excess  = SFR_BIT_VAL_I;
            CSF_POS_UF1:     nxt_state.uf1     = SFR_BIT_VAL_I;
            default: begin
               nxt_state.parity = state_ff.parity;
            end
         endcase
      end
      if (SFR_BIT_WR_I && hit_extra) begin
         nxt_state.extra[SFR_BIT_SEL_I] = SFR_BIT_VAL_I;
      end

      // Datapath flag updates; the user flags are never touched here.
      if (arith_active) begin
         nxt_state.carry  = au_carry;
         nxt_state.aux    = au_aux;
         nxt_state.excess = au_excess;
         if (au_res_hi_we) begin
            nxt_state.extra = au_res_hi;
         end
      end
      nxt_state.result     = arith_active ? au_res_lo : state_ff.result;
      nxt_state.result_vld = arith_active;

      // Parity follows the accumulator every cycle.
      nxt_state.parity = ^ACC_I;

      // Bank base plus register number gives the data address.
      nxt_state.reg_addr = {nxt_state.bank, REG_NUM_I};

      // Registered read data; unmapped addresses read as zero.
      nxt_state.rdata = CSF_RDATA_IDLE;
      if (SFR_RD_I) begin
         if (hit_status) begin
            nxt_state.rdata = status_view;
         end else if (hit_extra) begin
            nxt_state.rdata = state_ff.extra;
         end
      end
   end

   // ==========================================================================
   // State register
   // ==========================================================================
   always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         state_ff.extra      <= CSF_RST_EXTRA;
         state_ff.carry      <= CSF_RST_STATUS[CSF_POS_CARRY];
         state_ff.aux        <= CSF_RST_STATUS[CSF_POS_AUX];
         state_ff.uf0        <= CSF_RST_STATUS[CSF_POS_UF0];
         state_ff.bank       <= CSF_RST_STATUS[CSF_POS_BANK_HI:CSF_POS_BANK_LO];
         state_ff.excess     <= CSF_RST_STATUS[CSF_POS_EXCESS];
         state_ff.uf1        <= CSF_RST_STATUS[CSF_POS_UF1];
         state_ff.parity     <= CSF_RST_STATUS[CSF_POS_PARITY];
         state_ff.rdata      <= CSF_RDATA_IDLE;
         state_ff.result     <= CSF_ZERO_BYTE;
         state_ff.result_vld <= 1'b0;
         state_ff.reg_addr   <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   always_comb begin
      SFR_RDATA_O        = state_ff.rdata;
      ARITH_RESULT_O     = state_ff.result;
      ARITH_RESULT_VLD_O = state_ff.result_vld;
      REG_ADDR_O         = state_ff.reg_addr;
      PROGRAM_STATUS_O   = status_view;
      EXTRA_OPERAND_O    = state_ff.extra;
      BANK_SELECT_O      = state_ff.bank;
      CARRY_FLAG_O       = state_ff.carry;
   end

endmodule

`default_nettype wire

/* File: csf_status_flags_checker.sv */
// Concurrent checks on the ports of the status-flag block.
// Bound into csf_status_flags; one core clock, reset active high.

`timescale 1ns/1ps
`default_nettype none

module csf_status_flags_checker (
   input  wire logic                SYS_CLK_I,
   input  wire logic                SYS_RST_I,
   input  wire logic [7:0]          SFR_ADDR_I,
   input  wire logic                SFR_WR_I,
   input  wire logic                SFR_RD_I,
   input  wire logic                SFR_BIT_WR_I,
   input  wire logic [7:0]          SFR_RDATA_O,
   input  wire csf_pkg::csf_op_type ARITH_OP_I,
   input  wire logic [7:0]          ACC_I,
   input  wire logic [7:0]          OPERAND_I,
   input  wire logic [7:0]          ARITH_RESULT_O,
   input  wire logic [2:0]          REG_NUM_I,
   input  wire logic [4:0]          REG_ADDR_O,
   input  wire logic [7:0]          PROGRAM_STATUS_O,
   input  wire logic [7:0]          EXTRA_OPERAND_O,
   input  wire logic [1:0]          BANK_SELECT_O,
   input  wire logic                CARRY_FLAG_O
);
   import csf_pkg::*;

   logic [8:0] add_sum;
   logic [4:0] add_nib;
   logic       add_ovf;
   logic       unmapped;

   assign add_sum  = {1'b0, ACC_I} + {1'b0, OPERAND_I};
   assign add_nib  = {1'b0, ACC_I[3:0]} + {1'b0, OPERAND_I[3:0]};
   assign add_ovf  = (ACC_I[7] == OPERAND_I[7]) && (add_sum[7] != ACC_I[7]);
   assign unmapped = (SFR_ADDR_I != CSF_ADDR_STATUS) && (SFR_ADDR_I != CSF_ADDR_EXTRA);

   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (SYS_RST_I);

   // =========================================================================
   // Register reads
   // =========================================================================
   sequence s_status_rd;
      SFR_RD_I && (SFR_ADDR_I == CSF_ADDR_STATUS);
   endsequence
   sequence s_extra_rd;
      SFR_RD_I && (SFR_ADDR_I == CSF_ADDR_EXTRA);
   endsequence

   a_status_read: assert property (s_status_rd |=> SFR_RDATA_O == $past(PROGRAM_STATUS_O))
      else $error("status read returned wrong data");
   a_extra_read: assert property (s_extra_rd |=> SFR_RDATA_O == $past(EXTRA_OPERAND_O))
      else $error("extra operand read returned wrong data");
   a_idle_read_zero: assert property ((!SFR_RD_I || unmapped) |=> SFR_RDATA_O == 8'h00)
      else $error("read data not zero when idle or unmapped");

   // =========================================================================
   // Flags
   // =========================================================================
   a_parity_track: assert property (1'b1 |=>
      PROGRAM_STATUS_O[0] == ^$past(ACC_I))
      else $error("parity does not follow accumulator");
   a_add_flags: assert property (ARITH_OP_I == CSF_OP_ADD |=>
      CARRY_FLAG_O == $past(add_sum[8]) && PROGRAM_STATUS_O[CSF_POS_AUX] == $past(add_nib[4])
      && ARITH_RESULT_O == $past(add_sum[7:0]))
      else $error("add carry, aux carry or sum wrong");
   a_add_excess: assert property (ARITH_OP_I == CSF_OP_ADD |=>
      PROGRAM_STATUS_O[2] == $past(add_ovf))
      else $error("add signed overflow flag wrong");
   a_muldiv_clear: assert property (ARITH_OP_I inside {CSF_OP_MUL, CSF_OP_DIV} |=>
      !CARRY_FLAG_O && !PROGRAM_STATUS_O[CSF_POS_AUX])
      else $error("multiply or divide left a carry flag set");
   a_mul_excess: assert property (ARITH_OP_I == CSF_OP_MUL |=>
      PROGRAM_STATUS_O[CSF_POS_EXCESS] == (EXTRA_OPERAND_O != 8'h00))
      else $error("multiply overflow flag disagrees with high byte");
   a_div_zero: assert property (ARITH_OP_I == CSF_OP_DIV && EXTRA_OPERAND_O == 8'h00 |=>
      PROGRAM_STATUS_O[CSF_POS_EXCESS] && ARITH_RESULT_O == 8'h00 && EXTRA_OPERAND_O == 8'h00)
      else $error("divide by zero handled wrongly");
   a_user_flags: assert property (ARITH_OP_I != CSF_OP_NONE && !SFR_WR_I && !SFR_BIT_WR_I
      |=> $stable(PROGRAM_STATUS_O[5]) && $stable(PROGRAM_STATUS_O[1]))
      else $error("arithmetic altered a software flag");
   a_bank_addr: assert property (1'b1 |=>
      REG_ADDR_O == {BANK_SELECT_O, $past(REG_NUM_I)} && BANK_SELECT_O == PROGRAM_STATUS_O[4:3])
      else $error("working register address or bank wrong");
endmodule

bind csf_status_flags csf_status_flags_checker u_chk (.SYS_CLK_I(SYS_CLK_I),
   .SYS_RST_I(SYS_RST_I), .SFR_ADDR_I(SFR_ADDR_I), .SFR_WR_I(SFR_WR_I), .SFR_RD_I(SFR_RD_I),
   .SFR_BIT_WR_I(SFR_BIT_WR_I),
   .SFR_RDATA_O(SFR_RDATA_O), .ARITH_OP_I(ARITH_OP_I), .ACC_I(ACC_I), .OPERAND_I(OPERAND_I),
   .ARITH_RESULT_O(ARITH_RESULT_O), .REG_NUM_I(REG_NUM_I), .REG_ADDR_O(REG_ADDR_O),
   .PROGRAM_STATUS_O(PROGRAM_STATUS_O), .EXTRA_OPERAND_O(EXTRA_OPERAND_O),
   .BANK_SELECT_O(BANK_SELECT_O), .CARRY_FLAG_O(CARRY_FLAG_O));

`default_nettype wire

/* File: csf_core_model.sv */
// Core-side accumulator model feeding the status-flag block.
// Assumes the bench loads it and the block returns results with a valid pulse.

`timescale 1ns/1ps
`default_nettype none

module csf_core_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ld_i,
   input  wire logic [7:0] ld_val_i,
   input  wire logic [7:0] result_i,
   input  wire logic       result_vld_i,
   output logic [7:0]      acc_o
);
   // The core writes each returned result back into its accumulator unless a load arrives in the same cycle.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_o <= 8'h00;
      end else if (ld_i) begin
         acc_o <= ld_val_i;
      end else if (result_vld_i) begin
         acc_o <= result_i;
      end
   end
endmodule

`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the status-flag block.
// Assumes csf_pkg, the checker and the core model are compiled first.

`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import csf_pkg::*;

   typedef struct packed {
      csf_op_type op;
      logic [7:0] acc, opnd, ext;
      logic       cin;
      logic [7:0] res, st, ext_o;
   } csf_row_type;

   logic        clk = 1'b0, rst, wr_en, rd_en, bit_wr, bit_val, ld, vld;
   logic [7:0]  addr, wdata, rdata, acc, opnd, res, st, ext, ld_val;
   logic [2:0]  bit_sel, rnum;
   logic [4:0]  raddr;
   logic [1:0]  bank;
   logic        cy;
   csf_op_type  op;
   csf_row_type rows [10];
   csf_row_type r;
   int          error_cnt = 0, n_compared = 0;

   always #4 clk = ~clk;

   csf_status_flags dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .SFR_ADDR_I(addr), .SFR_WR_I(wr_en),
      .SFR_WDATA_I(wdata), .SFR_RD_I(rd_en), .SFR_BIT_WR_I(bit_wr), .SFR_BIT_SEL_I(bit_sel),
      .SFR_BIT_VAL_I(bit_val), .SFR_RDATA_O(rdata), .ARITH_OP_I(op), .ACC_I(acc),
      .OPERAND_I(opnd), .ARITH_RESULT_O(res), .ARITH_RESULT_VLD_O(vld), .REG_NUM_I(rnum),
      .REG_ADDR_O(raddr), .PROGRAM_STATUS_O(st), .EXTRA_OPERAND_O(ext),
      .BANK_SELECT_O(bank), .CARRY_FLAG_O(cy));

   csf_core_model u_core (.clk_i(clk), .rst_i(rst), .ld_i(ld), .ld_val_i(ld_val),
      .result_i(res), .result_vld_i(vld), .acc_o(acc));

   // =========================================================================
   // Tasks
   // =========================================================================
   task automatic cyc();
      @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      cyc();
      wr_en = 1'b0;
      cyc();
   endtask

   task automatic rd_byte(input logic [7:0] a, input logic [7:0] exp);
      addr = a;
      rd_en = 1'b1;
      cyc();
      rd_en = 1'b0;
      chk(rdata, exp);
      cyc();
   endtask

   task automatic wr_bit(input logic [7:0] a, input logic [2:0] s, input logic v);
      addr = a;
      bit_sel = s;
      bit_val = v;
      bit_wr = 1'b1;
      cyc();
      bit_wr = 1'b0;
      cyc();
   endtask

   task automatic stop_test();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      stop_test();
   end

   // =========================================================================
   // Main sequence
   // =========================================================================
   initial begin
      rst = 1'b1;
      {wr_en, rd_en, bit_wr, bit_val, ld} = '0;
      {addr, wdata, opnd, ld_val} = '0;
      {bit_sel, rnum} = '0;
      op = CSF_OP_NONE;
      rows = '{'{CSF_OP_ADD,  8'h7F, 8'h01, 8'h00, 1'b0, 8'h80, 8'h45, 8'h00},
               '{CSF_OP_ADD,  8'hFF, 8'h01, 8'h00, 1'b1, 8'h00, 8'hC0, 8'h00},
               '{CSF_OP_ADDC, 8'h0F, 8'h00, 8'h00, 1'b1, 8'h10, 8'h40, 8'h00},
               '{CSF_OP_ADDC, 8'h80, 8'h7F, 8'h00, 1'b1, 8'h00, 8'hC1, 8'h00},
               '{CSF_OP_SUBB, 8'h00, 8'h01, 8'h00, 1'b0, 8'hFF, 8'hC0, 8'h00},
               '{CSF_OP_SUBB, 8'h80, 8'h01, 8'h00, 1'b1, 8'h7E, 8'h45, 8'h00},
               '{CSF_OP_MUL,  8'h10, 8'h00, 8'h10, 1'b1, 8'h00, 8'h05, 8'h01},
               '{CSF_OP_MUL,  8'h03, 8'h00, 8'h04, 1'b1, 8'h0C, 8'h00, 8'h00},
               '{CSF_OP_DIV,  8'h07, 8'h00, 8'h02, 1'b1, 8'h03, 8'h01, 8'h01},
               '{CSF_OP_DIV,  8'h07, 8'h00, 8'h00, 1'b0, 8'h00, 8'h05, 8'h00}};
      repeat (16) cyc();
      rst = 1'b0;
      cyc();
      chk(st, 8'h00);
      chk(ext, 8'h00);
      rd_byte(CSF_ADDR_STATUS, 8'h00);
      rd_byte(CSF_ADDR_EXTRA, 8'h00);
      foreach (rows[i]) begin
         r = rows[i];
         ld = 1'b1;
         ld_val = r.acc;
         wr_byte(CSF_ADDR_EXTRA, r.ext);
         ld = 1'b0;
         wr_byte(CSF_ADDR_STATUS, r.cin ? 8'hC4 : 8'h00);
         op = r.op;
         opnd = r.opnd;
         cyc();
         op = CSF_OP_NONE;
         chk(res, r.res);
         chk(8'(vld), 8'h01);
         chk(8'(cy), 8'(r.st[CSF_POS_CARRY]));
         chk(st, r.st);
         chk(ext, r.ext_o);
         cyc();
         chk(8'(vld), 8'h00);
         cyc();
         chk(st[CSF_POS_PARITY], ^r.res);
      end
      // Parity bit ignores writes while the software flags keep theirs.
      wr_byte(CSF_ADDR_STATUS, 8'h23);
      rd_byte(CSF_ADDR_STATUS, 8'h22);
      op = CSF_OP_ADD;
      cyc();
      op = CSF_OP_NONE;
      chk(st & 8'h22, 8'h22);
      wr_bit(CSF_ADDR_STATUS, 3'h0, 1'b1);
      chk(st[CSF_POS_PARITY], 1'b0);
      wr_bit(CSF_ADDR_STATUS, 3'(CSF_POS_UF1), 1'b0);
      chk(st, 8'h20);
      wr_bit(CSF_ADDR_EXTRA, 3'h7, 1'b1);
      rd_byte(CSF_ADDR_EXTRA, 8'h80);
      wr_byte(8'hE0, 8'h55);
      chk(st, 8'h20);
      rd_byte(8'hE0, 8'h00);
      for (int b = 0; b < 4; b++) begin
         rnum = 3'(7 - b);
         wr_byte(CSF_ADDR_STATUS, 8'(b << 3));
         chk(bank, 8'(b));
         chk(raddr, {3'h0, b[1:0], rnum});
      end
      // A second reset in mid-run clears both registers again.
      wr_byte(CSF_ADDR_EXTRA, 8'h5A);
      rst = 1'b1;
      cyc();
      cyc();
      chk(st, 8'h00);
      chk(ext, 8'h00);
      rst = 1'b0;
      cyc();
      chk(st, 8'h00);
      rd_byte(CSF_ADDR_EXTRA, 8'h00);
      stop_test();
   end
endmodule

`default_nettype wire
